// [bench/cdg_host_model.sv]
// host controller model issuing single register accesses
// assumes the one-cycle strobe port of cdg_regs
`timescale 1ns/1ps
`default_nettype none
module cdg_host_model (
	input  wire logic       core_clk,   // clock
	output logic      [7:0] reg_addr,   // address
	output logic      [7:0] reg_wdata,  // write data
	output logic            reg_wr,     // write strobe
	output logic            reg_rd,     // read strobe
	input  wire logic [7:0] reg_rdata,  // read data
	input  wire logic       reg_rvalid  // read valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// idle bus shows inverted data, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
		v = reg_rvalid;
	endtask
endmodule // cdg_host_model
`default_nettype wire

// [bench/cdg_regs_asserts.sv]
// checker for the channel-8 trim and fault scan register bank
// assumes it is bound to cdg_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cdg_regs_asserts #(
	parameter int CHANNELS   = 4,
	parameter int SAMPLE_W   = 1,
	parameter int DELAY_BITS = 8
) (
	input wire logic                  core_clk,               // clock
	input wire logic                  sys_rst,                // reset
	input wire logic [7:0]            reg_addr,               // address
	input wire logic [7:0]            reg_wdata,              // write data
	input wire logic                  reg_wr,                 // write strobe
	input wire logic                  reg_rd,                 // read strobe
	input wire logic [7:0]            reg_rdata,              // read data
	input wire logic                  reg_rvalid,             // read valid
	input wire logic [3:0]            chan8_gain_trim_code,   // gain code
	input wire logic [4:0]            chan8_gain_tenths_db,   // gain tenths
	input wire logic [DELAY_BITS-1:0] chan8_phase_delay_code, // phase code
	input wire logic                  mod_en,                 // modulator enable
	input wire logic [SAMPLE_W-1:0]   chan8_dout,             // delayed stream
	input wire logic [CHANNELS-1:0]   analog_input_positive_pin, // pos mask
	input wire logic [CHANNELS-1:0]   analog_input_negative_pin  // neg mask
);
	import cdg_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// properties
	a_read_valid_pulse: assert property (reg_rvalid == $past(reg_rd)) else $error("rvalid not one cycle after read");
	a_gain_code_rst: assert property (disable iff (1'b0) sys_rst |=> chan8_gain_trim_code == 4'h8)
		else $error("gain code reset wrong");
	a_gain_write_lands: assert property (reg_wr && reg_addr == 8'h62 |=>
		chan8_gain_trim_code == $past(reg_wdata[7:4])) else $error("gain write lost");
	a_gain_tenths_map: assert property (##1 chan8_gain_tenths_db == $past({1'b0, chan8_gain_trim_code}) - 5'h08)
		else $error("gain tenths wrong");
	a_gain_low_zero: assert property (reg_rd && reg_addr == 8'h62 |=> reg_rdata[3:0] == 4'h0)
		else $error("gain low bits not zero");
	a_phase_write_lands: assert property (reg_wr && reg_addr == 8'h63 |=>
		chan8_phase_delay_code == $past(reg_wdata)) else $error("phase write lost");
	a_dout_holds_idle: assert property (!mod_en |=> $stable(chan8_dout)) else $error("dout moved");
	a_neg_within_pos: assert property ((analog_input_negative_pin & ~analog_input_positive_pin) == '0)
		else $error("neg pin without pos pin");
	c_gain_write: cover property (reg_wr && reg_addr == 8'h62);
	c_read: cover property (reg_rvalid);
	c_scan_on: cover property (analog_input_negative_pin != '0);
endmodule // cdg_regs_asserts
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for cdg_regs with a host model on the register port
// assumes cdg_pkg, cdg_regs and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cdg_pkg::*;
	logic core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, mod_en, chan8_din, chan8_dout;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, chan8_phase_delay_code;
	logic [3:0] chan8_gain_trim_code, chan_single_ended, chan_ac_coupled, pos, neg;
	logic [4:0] chan8_gain_tenths_db;
	int err_count = 0, n_checks = 0;
	cdg_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.chan8_gain_trim_code(chan8_gain_trim_code), .chan8_gain_tenths_db(chan8_gain_tenths_db),
		.chan8_phase_delay_code(chan8_phase_delay_code), .mod_en(mod_en), .chan8_din(chan8_din),
		.chan8_dout(chan8_dout), .chan_single_ended(chan_single_ended), .chan_ac_coupled(chan_ac_coupled),
		.analog_input_positive_pin(pos), .analog_input_negative_pin(neg));
	cdg_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// ==========================================
	// checking helpers
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("rvalid", {7'h0, v}, 8'h01);
		chk("rdata", d, e);
	endtask
	task automatic results;
		$display("errors %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		rdc(8'h62, 8'h80);
		rdc(8'h63, 8'h00);
		rdc(8'h64, 8'h00);
		chk("tenths", {3'h0, chan8_gain_tenths_db}, 8'h00);
		chk("pos", {4'h0, pos}, 8'h00);
		chk("neg", {4'h0, neg}, 8'h00);
	endtask
	task automatic t_gain;
		logic [3:0] c[7] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hb, 4'he, 4'hf};
		logic [4:0] t[7] = '{5'h18, 5'h1b, 5'h00, 5'h01, 5'h03, 5'h06, 5'h07};
		for (int i = 0; i < 7; i++) begin
			host.wr(8'h62, {c[i], 4'h0});
			@(posedge core_clk);
			#1 chk("tenths", {3'h0, chan8_gain_tenths_db}, {3'h0, t[i]});
			rdc(8'h62, {c[i], 4'h0});
		end
		host.wr(8'h70, 8'hff);
		rdc(8'h70, 8'h00);
		rdc(8'h62, 8'hf0);
	endtask
	task automatic t_phase(input logic [7:0] d);
		logic [7:0] h = 8'h69;
		host.wr(8'h63, d);
		for (int k = 0; k < 7; k++) begin
			@(posedge core_clk);
			#1 mod_en = 1'b1;
			chan8_din = h[k];
			@(posedge core_clk);
			#1 mod_en = 1'b0;
			if (k >= d) chk("dout", {7'h0, chan8_dout}, {7'h0, h[k-d]});
		end
	endtask
	task automatic t_scan(input logic [7:0] s, input logic [3:0] se, input logic [3:0] ac);
		logic [3:0] p, n;
		chan_single_ended = se;
		chan_ac_coupled = ac;
		host.wr(8'h64, s);
		repeat (2) @(posedge core_clk);
		#1 for (int i = 0; i < 4; i++) begin
			p[i] = s[7-i] & (~ac[i] | s[0]);
			n[i] = p[i] & (~se[i] | s[1]);
		end
		chk("pos", {4'h0, pos}, {4'h0, p});
		chk("neg", {4'h0, neg}, {4'h0, n});
		rdc(8'h64, s);
	endtask
	task automatic t_rst_mid;
		@(posedge core_clk);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		t_reset();
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#40000 err_count++;
		results();
	end
	initial begin
		sys_rst = 1'b1;
		mod_en = 1'b0;
		chan8_din = 1'b0;
		chan_single_ended = 4'h0;
		chan_ac_coupled = 4'h0;
		repeat (12) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		t_reset();
		t_gain();
		t_phase(8'h00);
		t_phase(8'h02);
		rdc(8'h63, 8'h02);
		t_phase(8'h05);
		t_scan(8'hf0, 4'h5, 4'h3);
		t_scan(8'hf2, 4'h5, 4'h3);
		t_scan(8'hf1, 4'h5, 4'h3);
		t_scan(8'ha3, 4'hf, 4'hc);
		t_rst_mid();
		results();
	end
endmodule // testbench
bind cdg_regs cdg_regs_asserts #(.CHANNELS(CHANNELS), .SAMPLE_W(SAMPLE_W), .DELAY_BITS(DELAY_BITS)) chk_i (
	.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan8_gain_trim_code(chan8_gain_trim_code),
	.chan8_gain_tenths_db(chan8_gain_tenths_db), .chan8_phase_delay_code(chan8_phase_delay_code),
	.mod_en(mod_en), .chan8_dout(chan8_dout), .analog_input_positive_pin(analog_input_positive_pin),
	.analog_input_negative_pin(analog_input_negative_pin));
`default_nettype wire

// [logic/cdg_delay_line.sv]
// programmable delay line, advanced once per modulator clock enable
// assumes mod_en is a one-cycle pulse in the core_clk domain
`timescale 1ns/1ps
`default_nettype none
module cdg_delay_line #(
	parameter int WIDTH = 1,
	parameter int DEPTH_LOG2 = 8
) (
	input  wire logic                  core_clk,  // core clock
	input  wire logic                  sys_rst,   // sync reset, active high
	input  wire logic                  mod_en,    // modulator clock enable
	input  wire logic [DEPTH_LOG2-1:0] delay,     // delay in enables
	input  wire logic [WIDTH-1:0]      din,       // undelayed stream
	output logic      [WIDTH-1:0]      dout       // delayed stream
);
	import cdg_pkg::*;

	logic [WIDTH-1:0]      mem [0:(1<<DEPTH_LOG2)-1];
	logic [DEPTH_LOG2-1:0] wr_ptr_reg;
	logic [DEPTH_LOG2-1:0] wr_ptr_next;
	logic [WIDTH-1:0]      dout_reg;
	logic [WIDTH-1:0]      dout_next;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		dout_next   = dout_reg;
		if (mod_en) begin
			wr_ptr_next = wr_ptr_reg + 1'b1;
			// delay of zero bypasses the memory; else take the sample written delay enables ago
			if (delay == '0) begin
				dout_next = din;
			end else begin
				dout_next = mem[wr_ptr_reg - delay];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (mod_en) begin
			mem[wr_ptr_reg] <= din;
		end
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			dout_reg   <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			dout_reg   <= dout_next;
		end
	end

	assign dout = dout_reg;
endmodule // cdg_delay_line
`default_nettype wire

// [logic/cdg_pkg.sv]
// constants for the channel-8 trim and fault scan selection registers
// assumes an 8-bit register address and data path from the control port
package cdg_pkg;

	// ==========================================
	// register offsets
	localparam logic [7:0] CDG_ADDR_GAIN_TRIM  = 8'h62;
	localparam logic [7:0] CDG_ADDR_PHASE_TRIM = 8'h63;
	localparam logic [7:0] CDG_ADDR_SCAN_SEL   = 8'h64;

	// ==========================================
	// reset values
	localparam logic [7:0] CDG_RST_GAIN_TRIM  = 8'h80;
	localparam logic [7:0] CDG_RST_PHASE_TRIM = 8'h00;
	localparam logic [7:0] CDG_RST_SCAN_SEL   = 8'h00;

	// ==========================================
	// field positions
	localparam int CDG_GAIN_LSB      = 4;
	localparam int CDG_GAIN_MSB      = 7;
	localparam int CDG_SCAN_CH1_BIT  = 7;
	localparam int CDG_SCAN_CH4_BIT  = 4;
	localparam int CDG_INCL_SE_BIT   = 1;
	localparam int CDG_INCL_AC_BIT   = 0;

	// gain code that maps to 0 dB; one code step is 0.1 dB
	localparam logic [3:0] CDG_GAIN_ZERO_CODE = 4'h8;

	// ==========================================
	// decoding used by the register bank
	function automatic logic [4:0] cdg_gain_tenths(input logic [3:0] code);
		cdg_gain_tenths = {1'b0, code} - {1'b0, CDG_GAIN_ZERO_CODE};
	endfunction

endpackage

// [logic/cdg_regs.sv]
// channel-8 gain and phase trim plus fault scan selection register bank
// assumes the control port decoder delivers one-cycle read and write strobes
//
// What this block does
// - gain trim in bits 7..4, reset 8; code 0 is -0.8 dB, 8 is 0 dB
// - code 9 gives +0.1 dB, 14 gives +0.6 dB, 15 gives +0.7 dB
// - gain register bits 3..0 read zero; host writes zero there
// - 8-bit phase trim, reset 0, delays channel by code modulator cycles
// - bits 7..4 enable scan of both pins of channels 1..4, reset off
// - bit 1 includes negative pins of single-ended channels in scan
// - bit 0 includes both pins of AC-coupled channels in scan
`timescale 1ns/1ps
`default_nettype none
module cdg_regs #(
	parameter int CHANNELS   = 4,
	parameter int SAMPLE_W   = 1,
	parameter int DELAY_BITS = 8
) (
	input  wire logic                core_clk,           // 250 MHz core clock
	input  wire logic                sys_rst,            // sync reset, active high
	input  wire logic [7:0]          reg_addr,           // register address
	input  wire logic [7:0]          reg_wdata,          // write data
	input  wire logic                reg_wr,             // write strobe
	input  wire logic                reg_rd,             // read strobe
	output logic      [7:0]          reg_rdata,          // read data, one cycle after strobe
	output logic                     reg_rvalid,         // read data valid pulse
	output logic      [3:0]          chan8_gain_trim_code,     // raw gain code
	output logic      [4:0]          chan8_gain_tenths_db,     // signed gain in 0.1 dB
	output logic      [DELAY_BITS-1:0] chan8_phase_delay_code, // delay in modulator cycles
	input  wire logic                mod_en,             // modulator clock enable
	input  wire logic [SAMPLE_W-1:0] chan8_din,          // channel 8 modulator stream
	output logic      [SAMPLE_W-1:0] chan8_dout,         // delayed channel 8 stream
	input  wire logic [CHANNELS-1:0] chan_single_ended,  // channel i wired single-ended
	input  wire logic [CHANNELS-1:0] chan_ac_coupled,    // channel i AC-coupled
	output logic [CHANNELS-1:0]      analog_input_positive_pin, // scan positive pin of channel i
	output logic [CHANNELS-1:0]      analog_input_negative_pin  // scan negative pin of channel i
);
	import cdg_pkg::*;

	// ==========================================
	// register state
	logic [3:0]          gain_reg;
	logic [3:0]          gain_next;
	logic [7:0]          phase_reg;
	logic [7:0]          phase_next;
	logic [7:0]          scan_reg;
	logic [7:0]          scan_next;
	logic [7:0]          rdata_reg;
	logic [7:0]          rdata_next;
	logic                rvalid_reg;
	logic                rvalid_next;
	logic [4:0]          tenths_reg;
	logic [4:0]          tenths_next;
	logic [CHANNELS-1:0] pos_reg;
	logic [CHANNELS-1:0] pos_next;
	logic [CHANNELS-1:0] neg_reg;
	logic [CHANNELS-1:0] neg_next;

	logic [CHANNELS-1:0] chan_scan_enable;
	logic                include_single_ended_neg_pin;
	logic                include_ac_coupled_pins;
	logic [1:0]          wr_sel;
	logic [1:0]          rd_sel;

	// ==========================================
	// address decode
	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_GAIN  = 2'h1;
	localparam logic [1:0] SEL_PHASE = 2'h2;
	localparam logic [1:0] SEL_SCAN  = 2'h3;

	// one map for both directions, so a write and a read of one offset always meet the same register
	function automatic logic [1:0] reg_select(input logic [7:0] addr);
		case (addr)
			CDG_ADDR_GAIN_TRIM:  reg_select = SEL_GAIN;
			CDG_ADDR_PHASE_TRIM: reg_select = SEL_PHASE;
			CDG_ADDR_SCAN_SEL:   reg_select = SEL_SCAN;
			default:             reg_select = SEL_NONE;
		endcase
	endfunction

	// a pin joins the scan when its channel is on, unless its kind is excluded by a clear include bit
	function automatic logic pin_in_scan(input logic enabled, input logic of_kind, input logic include_kind);
		pin_in_scan = enabled & (~of_kind | include_kind);
	endfunction

	assign wr_sel = reg_wr ? reg_select(reg_addr) : SEL_NONE;
	assign rd_sel = reg_rd ? reg_select(reg_addr) : SEL_NONE;

	// ==========================================
	// scan selection fields
	// channel 1 sits in the top bit, so reverse into channel order
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			chan_scan_enable[i] = scan_reg[CDG_SCAN_CH1_BIT - i];
		end
		include_single_ended_neg_pin = scan_reg[CDG_INCL_SE_BIT];
		include_ac_coupled_pins      = scan_reg[CDG_INCL_AC_BIT];
	end

	// ==========================================
	// register writes
	always_comb begin
		gain_next  = gain_reg;
		phase_next = phase_reg;
		scan_next  = scan_reg;
		case (wr_sel)
			SEL_GAIN: begin
				// low nibble is read-only, write data there is dropped
				gain_next = reg_wdata[CDG_GAIN_MSB:CDG_GAIN_LSB];
			end
			SEL_PHASE: begin
				phase_next = reg_wdata;
			end
			SEL_SCAN: begin
				// reserved bits 3..2 are stored as written; host keeps them zero
				scan_next = reg_wdata;
			end
			default: begin
				gain_next = gain_reg;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gain_reg  <= CDG_RST_GAIN_TRIM[CDG_GAIN_MSB:CDG_GAIN_LSB];
			phase_reg <= CDG_RST_PHASE_TRIM;
			scan_reg  <= CDG_RST_SCAN_SEL;
		end else begin
			gain_reg  <= gain_next;
			phase_reg <= phase_next;
			scan_reg  <= scan_next;
		end
	end

	// ==========================================
	// read port
	// a read in the cycle of a write to the same offset returns the old value
	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = reg_rd;
		if (reg_rd) begin
			case (rd_sel)
				SEL_GAIN:  rdata_next = {gain_reg, 4'h0};
				SEL_PHASE: rdata_next = phase_reg;
				SEL_SCAN:  rdata_next = scan_reg;
				default:   rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ==========================================
	// gain decode
	always_comb begin
		// linear 0.1 dB per code around code 8 covers every listed point
		tenths_next = cdg_gain_tenths(gain_reg);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tenths_reg <= 5'h00;
		end else begin
			tenths_reg <= tenths_next;
		end
	end

	// ==========================================
	// scan pin masks
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			// AC-coupled channels drop both pins unless included
			pos_next[i] = pin_in_scan(chan_scan_enable[i], chan_ac_coupled[i], include_ac_coupled_pins);
			neg_next[i] = pin_in_scan(pos_next[i], chan_single_ended[i], include_single_ended_neg_pin);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pos_reg <= '0;
			neg_reg <= '0;
		end else begin
			pos_reg <= pos_next;
			neg_reg <= neg_next;
		end
	end

	// ==========================================
	// channel 8 phase delay
	// delay memory is not reset: after a longer delay is set, the first outputs replay stale samples
	cdg_delay_line #(
		.WIDTH      (SAMPLE_W),
		.DEPTH_LOG2 (DELAY_BITS)
	) u_delay (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.mod_en   (mod_en),
		.delay    (phase_reg[DELAY_BITS-1:0]),
		.din      (chan8_din),
		.dout     (chan8_dout)
	);

	assign reg_rdata                 = rdata_reg;
	assign reg_rvalid                = rvalid_reg;
	assign chan8_gain_trim_code      = gain_reg;
	assign chan8_gain_tenths_db      = tenths_reg;
	assign chan8_phase_delay_code    = phase_reg[DELAY_BITS-1:0];
	assign analog_input_positive_pin = pos_reg;
	assign analog_input_negative_pin = neg_reg;
endmodule // cdg_regs
`default_nettype wire
